// [design/mdof_consts.vh]
`ifndef MDOF_CONSTS_VH
`define MDOF_CONSTS_VH

// field lengths in bytes
`define MDOF_HDR_LEN      5'h08
`define MDOF_DATA_LEN     5'h0b
`define MDOF_WORD_LEN     5'h04
`define MDOF_END_LEN      5'h03

// ascii characters
`define MDOF_CH_SPACE     8'h20
`define MDOF_CH_MINUS     8'h2d
`define MDOF_CH_PLUS      8'h2b
`define MDOF_CH_COMMA     8'h2c
`define MDOF_CH_DOT       8'h2e
`define MDOF_CH_PCT       8'h25
`define MDOF_CH_ZERO      8'h30
`define MDOF_CH_E         8'h45
`define MDOF_CH_N         8'h4e
`define MDOF_CH_D         8'h44
`define MDOF_CH_CR        8'h0d
`define MDOF_CH_LF        8'h0a

// exponent scale codes
`define MDOF_SC_MILLI     2'h0
`define MDOF_SC_UNIT      2'h1
`define MDOF_SC_KILO      2'h2
`define MDOF_SC_MEGA      2'h3

// layout codes
`define MDOF_LAY_MANUAL   2'h0
`define MDOF_LAY_ONE      2'h1
`define MDOF_LAY_TWO      2'h2

// element-two line ranges and motor line, one-based
`define MDOF_MAN_E2_FIRST 5'h0a
`define MDOF_MAN_E2_LAST  5'h12
`define MDOF_MAN_MOTOR    5'h1e
`define MDOF_D1_E2_FIRST  5'h08
`define MDOF_D1_E2_LAST   5'h0e
`define MDOF_D2_E2_FIRST  5'h04
`define MDOF_D2_E2_LAST   5'h06

// binary special codes, nearest single values
`define MDOF_BIN_INF      32'h7e94f56a
`define MDOF_BIN_NAN      32'h7e951bf9
`define MDOF_EXP_RSVD     8'hff

// output buffer
`define MDOF_FIFO_DEPTH   32

`endif

// [design/mdof_formatter.v]
`timescale 1ns/100ps
`include "mdof_consts.vh"

// byte buffer between the framer and the link
module mdof_fifo #(
   parameter WIDTH = 9,                     // word width
   parameter DEPTH = `MDOF_FIFO_DEPTH,      // words held
   parameter AW    = 5                      // address bits
) (
   input  wire             clk_sys,         // system clock
   input  wire             rst,             // async reset
   input  wire             ce,              // clock enable
   input  wire             inValid,         // write request
   output wire             inReady,         // room for a word
   input  wire [WIDTH-1:0] inData,          // write data
   output wire             outValid,        // word available
   input  wire             outReady,        // reader takes word
   output wire [WIDTH-1:0] outData          // head word
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];        // storage
   reg  [AW:0]      wrPtr;                  // write pointer with wrap bit
   reg  [AW:0]      rdPtr;                  // read pointer with wrap bit
   wire             full;                   // all words used
   wire             empty;                  // nothing stored
   wire             doWr;                   // write this cycle
   wire             doRd;                   // read this cycle

   assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   assign empty    = (wrPtr == rdPtr);
   assign inReady  = !full && ce;
   assign outValid = !empty && ce;
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;
   assign outData  = mem[rdPtr[AW-1:0]];

   // storage write, no reset needed on data
   always @(posedge clk_sys) begin
      if (doWr) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end

   // pointer update
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPtr <= {(AW+1){1'b0}};
         rdPtr <= {(AW+1){1'b0}};
      end else begin
         if (doWr) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (doRd) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end
endmodule

// harmonic measurement output framer
module mdof_formatter #(
   parameter FIFO_DEPTH = `MDOF_FIFO_DEPTH, // output buffer words
   parameter FIFO_AW    = 5                 // output buffer address bits
) (
   input  wire        clk_sys,              // system clock
   input  wire        rst,                  // async reset, active high
   input  wire        ce,                   // clock enable
   input  wire        cfgBinary,            // binary output format
   input  wire        cfgHeaderOn,          // ascii headers enabled
   input  wire        cfgTermCrLf,          // terminator cr lf, else lf
   input  wire [1:0]  cfgLayout,            // manual, layout one, layout two
   input  wire [5:0]  cfgMaxOrder,          // maximum harmonic order
   input  wire        cfgThreeWire,         // three-phase three-wire unit
   input  wire        cfgMotorVariant,      // motor evaluation unit
   input  wire        itemValid,            // item offered
   output wire        itemReady,            // item taken
   input  wire        itemSelected,         // item chosen for output
   input  wire [4:0]  itemLine,             // line number, one-based
   input  wire        itemLineEnd,          // last item of its line
   input  wire        itemBlockEnd,         // last item of the block
   input  wire [23:0] itemType,             // three type characters
   input  wire [7:0]  itemElement,          // element character
   input  wire [7:0]  itemState,            // data state character
   input  wire [5:0]  itemOrder,            // order, zero for none
   input  wire [7:0]  itemPhase,            // lead or lag character
   input  wire        itemNegative,         // value below zero
   input  wire [23:0] itemDigits,           // six bcd digits, msd first
   input  wire [2:0]  itemPoint,            // digits before the point
   input  wire [1:0]  itemScale,            // exponent scale code
   input  wire        itemPercent,          // percent-type item
   input  wire [31:0] itemFloat,            // single real value
   input  wire        itemOverflow,         // overrange or overflow
   input  wire        itemIsTime,           // elapsed integration time
   input  wire        itemTimeValid,        // elapsed time available
   input  wire [15:0] itemHours,            // elapsed hours
   input  wire [7:0]  itemMinutes,          // elapsed minutes
   input  wire [7:0]  itemSeconds,          // elapsed seconds
   output wire        outValid,             // byte available
   input  wire        outReady,             // host takes byte
   output wire [7:0]  outData,              // byte
   output wire        outEoi                // end-or-identify with byte
);
   // framer states
   localparam [2:0] S_IDLE  = 3'h0;         // waiting for an item
   localparam [2:0] S_COMMA = 3'h1;         // separator
   localparam [2:0] S_HDR   = 3'h2;         // header bytes
   localparam [2:0] S_DATA  = 3'h3;         // data field
   localparam [2:0] S_TERM  = 3'h4;         // line terminator
   localparam [2:0] S_END   = 3'h5;         // end line text
   localparam [2:0] S_BIN   = 3'h6;         // binary word
   localparam [2:0] S_FLUSH = 3'h7;         // last binary byte

   reg  [2:0]  state;                       // framer state
   reg  [4:0]  idx;                         // byte index in state
   reg         lineOpen;                    // current line has an item
   reg         inEndLine;                   // terminator closes end line
   reg         pendValid;                   // held binary byte present
   reg  [7:0]  pendByte;                    // held binary byte
   reg  [23:0] rType;                       // latched type
   reg  [7:0]  rElem;                       // latched element
   reg  [7:0]  rState;                      // latched state
   reg  [5:0]  rOrder;                      // latched order
   reg  [7:0]  rPhase;                      // latched phase
   reg         rNeg;                        // latched sign
   reg  [23:0] rDigits;                     // latched digits
   reg  [2:0]  rPoint;                      // latched point position
   reg  [1:0]  rScale;                      // latched scale
   reg         rPercent;                    // latched percent flag
   reg  [31:0] rWord;                       // latched binary word
   reg         rLineEnd;                    // latched line end
   reg         rBlockEnd;                   // latched block end
   reg  [7:0]  curByte;                     // byte for this step
   reg         curPush;                     // step writes a byte
   reg         curEoi;                      // step byte ends block
   reg         lastStep;                    // step finishes the state
   reg  [2:0]  afterState;                  // state after the last step
   reg         lineDrop;                    // item line not emitted
   reg  [31:0] next_word;                   // binary word of offered item
   wire        keep;                        // offered item goes out
   wire        take;                        // item accepted this cycle
   wire        fifoReady;                   // buffer has room
   wire        stepGo;                      // current step completes
   wire [5:0]  tens;                        // order tens digit
   wire [5:0]  ones;                        // order ones digit
   wire [8:0]  fifoOut;                     // buffered byte and eoi

   assign tens = rOrder / 6'h0a;
   assign ones = rOrder % 6'h0a;

   // one mantissa character, point placed after pt digits
   function [7:0] mantChar;
      input [23:0] dg;
      input [2:0]  pt;
      input [2:0]  pos;
      reg   [2:0]  n;
      begin
         n = (pos > pt) ? pos - 3'h1 : pos;
         case (n)
            3'h0:    mantChar = {4'h3, dg[23:20]};
            3'h1:    mantChar = {4'h3, dg[19:16]};
            3'h2:    mantChar = {4'h3, dg[15:12]};
            3'h3:    mantChar = {4'h3, dg[11:8]};
            3'h4:    mantChar = {4'h3, dg[7:4]};
            default: mantChar = {4'h3, dg[3:0]};
         endcase
         if (pos == pt) begin
            mantChar = `MDOF_CH_DOT;
         end
      end
   endfunction

   // lines removed by hardware variant and layout
   always @* begin
      lineDrop = 1'b0;
      case (cfgLayout)
         `MDOF_LAY_MANUAL: begin
            lineDrop = (cfgThreeWire && itemLine >= `MDOF_MAN_E2_FIRST
                        && itemLine <= `MDOF_MAN_E2_LAST)
                       || (itemLine == `MDOF_MAN_MOTOR && !cfgMotorVariant);
         end
         `MDOF_LAY_ONE: begin
            lineDrop = cfgThreeWire && itemLine >= `MDOF_D1_E2_FIRST
                       && itemLine <= `MDOF_D1_E2_LAST;
         end
         `MDOF_LAY_TWO: begin
            lineDrop = cfgThreeWire && itemLine >= `MDOF_D2_E2_FIRST
                       && itemLine <= `MDOF_D2_E2_LAST;
         end
         default: begin
            lineDrop = 1'b0;
         end
      endcase
   end

   // deselected, over-order and dropped-line items vanish
   assign keep = itemSelected && (itemOrder <= cfgMaxOrder) && !lineDrop;
   assign take = itemValid && ce && (state == S_IDLE);
   assign itemReady = ce && (state == S_IDLE);

   // binary word with special codes
   always @* begin
      if (itemIsTime) begin
         next_word = itemTimeValid ? {itemHours, itemMinutes, itemSeconds}
                                   : `MDOF_BIN_NAN;
      end else if (itemOverflow || itemFloat[30:23] == `MDOF_EXP_RSVD) begin
         next_word = `MDOF_BIN_INF;
      end else begin
         next_word = itemFloat;
      end
   end

   // byte of the current step and where the state goes next
   always @* begin
      curByte    = `MDOF_CH_SPACE;
      curPush    = 1'b1;
      curEoi     = 1'b0;
      lastStep   = 1'b0;
      afterState = S_IDLE;
      case (state)
         S_COMMA: begin
            curByte    = `MDOF_CH_COMMA;
            lastStep   = 1'b1;
            afterState = cfgHeaderOn ? S_HDR : S_DATA;
         end
         S_HDR: begin
            lastStep   = (idx == `MDOF_HDR_LEN - 5'h01);
            afterState = S_DATA;
            case (idx[2:0])
               3'h0:    curByte = rType[23:16];
               3'h1:    curByte = rType[15:8];
               3'h2:    curByte = rType[7:0];
               3'h3:    curByte = rElem;
               3'h4:    curByte = rState;
               3'h5:    curByte = (rOrder == 6'h00) ? `MDOF_CH_SPACE : {4'h3, tens[3:0]};
               3'h6:    curByte = (rOrder == 6'h00) ? `MDOF_CH_SPACE : {4'h3, ones[3:0]};
               default: curByte = rPhase;
            endcase
         end
         S_DATA: begin
            lastStep   = (idx == `MDOF_DATA_LEN - 5'h01);
            afterState = rLineEnd ? S_TERM : (rBlockEnd ? S_END : S_IDLE);
            if (idx == 5'h00) begin
               curByte = rNeg ? `MDOF_CH_MINUS : `MDOF_CH_SPACE;
            end else if (idx <= 5'h07) begin
               curByte = mantChar(rDigits, rPoint, idx[2:0] - 3'h1);
            end else if (rPercent) begin
               curByte = (idx == 5'h08) ? `MDOF_CH_PCT : `MDOF_CH_SPACE;
            end else if (idx == 5'h08) begin
               curByte = `MDOF_CH_E;
            end else if (idx == 5'h09) begin
               curByte = (rScale == `MDOF_SC_MILLI) ? `MDOF_CH_MINUS : `MDOF_CH_PLUS;
            end else begin
               case (rScale)
                  `MDOF_SC_MILLI: curByte = 8'h33;
                  `MDOF_SC_UNIT:  curByte = `MDOF_CH_ZERO;
                  `MDOF_SC_KILO:  curByte = 8'h33;
                  default:        curByte = 8'h36;
               endcase
            end
         end
         S_TERM: begin
            lastStep   = cfgTermCrLf ? (idx == 5'h01) : 1'b1;
            curByte    = (cfgTermCrLf && idx == 5'h00) ? `MDOF_CH_CR : `MDOF_CH_LF;
            curEoi     = lastStep && inEndLine;
            afterState = (rBlockEnd && !inEndLine) ? S_END : S_IDLE;
         end
         S_END: begin
            lastStep   = (idx == `MDOF_END_LEN - 5'h01);
            afterState = S_TERM;
            case (idx[1:0])
               2'h0:    curByte = `MDOF_CH_E;
               2'h1:    curByte = `MDOF_CH_N;
               default: curByte = `MDOF_CH_D;
            endcase
         end
         S_BIN: begin
            // step 0 releases the held byte, steps 1-3 send the top three
            lastStep   = (idx == `MDOF_WORD_LEN - 5'h01);
            afterState = rBlockEnd ? S_FLUSH : S_IDLE;
            case (idx[1:0])
               2'h0: begin
                  curByte = pendByte;
                  curPush = pendValid;
               end
               2'h1:    curByte = rWord[31:24];
               2'h2:    curByte = rWord[23:16];
               default: curByte = rWord[15:8];
            endcase
         end
         S_FLUSH: begin
            curByte  = pendByte;
            curPush  = pendValid;
            curEoi   = 1'b1;
            lastStep = 1'b1;
         end
         default: begin
            curPush = 1'b0;
         end
      endcase
   end

   assign stepGo = ce && (state != S_IDLE) && (!curPush || fifoReady);

   // framer sequence
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state     <= S_IDLE;
         idx       <= 5'h00;
         lineOpen  <= 1'b0;
         inEndLine <= 1'b0;
         pendValid <= 1'b0;
         pendByte  <= 8'h00;
         rType     <= 24'h000000;
         rElem     <= 8'h00;
         rState    <= 8'h00;
         rOrder    <= 6'h00;
         rPhase    <= 8'h00;
         rNeg      <= 1'b0;
         rDigits   <= 24'h000000;
         rPoint    <= 3'h0;
         rScale    <= 2'h0;
         rPercent  <= 1'b0;
         rWord     <= 32'h00000000;
         rLineEnd  <= 1'b0;
         rBlockEnd <= 1'b0;
      end else if (take) begin
         // latch the offered item and pick the first state
         rType     <= itemType;
         rElem     <= itemElement;
         rState    <= itemState;
         rOrder    <= itemOrder;
         rPhase    <= itemPhase;
         rNeg      <= itemNegative;
         rDigits   <= itemDigits;
         rPoint    <= itemPoint;
         rScale    <= itemScale;
         rPercent  <= itemPercent;
         rWord     <= next_word;
         rLineEnd  <= itemLineEnd;
         rBlockEnd <= itemBlockEnd;
         idx       <= 5'h00;
         if (cfgBinary) begin
            // no header, comma or terminator in binary
            state <= keep ? S_BIN : (itemBlockEnd ? S_FLUSH : S_IDLE);
         end else if (keep) begin
            lineOpen <= 1'b1;
            state    <= lineOpen ? S_COMMA : (cfgHeaderOn ? S_HDR : S_DATA);
         end else if (itemLineEnd && lineOpen) begin
            state <= S_TERM;
         end else if (itemBlockEnd) begin
            state <= S_END;
         end
      end else if (stepGo) begin
         if (lastStep) begin
            state <= afterState;
            idx   <= 5'h00;
            if (state == S_TERM) begin
               lineOpen  <= 1'b0;
               inEndLine <= 1'b0;
            end
            if (state == S_END) begin
               inEndLine <= 1'b1;
            end
            if (state == S_BIN) begin
               pendByte  <= rWord[7:0];
               pendValid <= 1'b1;
            end
            if (state == S_FLUSH) begin
               pendValid <= 1'b0;
            end
         end else begin
            idx <= idx + 5'h01;
         end
      end
   end

   // output buffer, back-pressure stalls the framer
   mdof_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .inValid  (curPush && state != S_IDLE),
      .inReady  (fifoReady),
      .inData   ({curEoi, curByte}),
      .outValid (outValid),
      .outReady (outReady),
      .outData  (fifoOut)
   );

   assign outData = fifoOut[7:0];
   assign outEoi  = fifoOut[8];
endmodule

// [verification/mdof_formatter_asserts.sv]
`timescale 1ns/100ps
`include "mdof_consts.vh"

// port-level checks for the harmonic output framer
module mdof_formatter_asserts (
   input wire       clk_sys,          // system clock
   input wire       rst,              // async reset
   input wire       ce,               // clock enable
   input wire       cfgBinary,        // binary format
   input wire [1:0] cfgLayout,        // layout code
   input wire [5:0] cfgMaxOrder,      // maximum order
   input wire       cfgThreeWire,     // three-wire unit
   input wire       cfgMotorVariant,  // motor unit
   input wire       itemValid,        // item offered
   input wire       itemReady,        // item taken
   input wire       itemSelected,     // item chosen
   input wire [4:0] itemLine,         // line number
   input wire       itemLineEnd,      // last of line
   input wire       itemBlockEnd,     // last of block
   input wire [5:0] itemOrder,        // harmonic order
   input wire       outValid,         // byte offered
   input wire       outReady,         // host takes byte
   input wire [7:0] outData,          // byte
   input wire       outEoi            // end marker
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire manual = cfgLayout == `MDOF_LAY_MANUAL;  // manual selection
   // an item accepted by the framer
   sequence sTake; itemValid && itemReady; endsequence
   // an accepted item that closes neither line nor block
   sequence sPass; sTake ##0 !itemLineEnd && !itemBlockEnd; endsequence
   // a dropped item frees the item port at once
   property pDrop(c); sPass ##0 c |-> ##[1:2] (itemReady || !ce); endproperty
   AST_DROP_ORDER: assert property (pDrop(itemOrder > cfgMaxOrder))
      else $error("item above maximum order not dropped");
   AST_DROP_UNSEL: assert property (pDrop(!itemSelected))
      else $error("deselected item left a gap");
   AST_DROP_MAN3W: assert property (pDrop(manual && cfgThreeWire && itemLine >= `MDOF_MAN_E2_FIRST
      && itemLine <= `MDOF_MAN_E2_LAST))
      else $error("manual element-two line not dropped");
   AST_DROP_MOTOR: assert property (pDrop(manual && !cfgMotorVariant && itemLine == `MDOF_MAN_MOTOR))
      else $error("motor line not dropped");
   AST_DROP_D1: assert property (pDrop(cfgLayout == `MDOF_LAY_ONE && cfgThreeWire
      && itemLine >= `MDOF_D1_E2_FIRST && itemLine <= `MDOF_D1_E2_LAST))
      else $error("layout one element-two line not dropped");
   AST_DROP_D2: assert property (pDrop(cfgLayout == `MDOF_LAY_TWO && cfgThreeWire
      && itemLine >= `MDOF_D2_E2_FIRST && itemLine <= `MDOF_D2_E2_LAST))
      else $error("layout two element-two line not dropped");
   AST_KEPT_BUSY: assert property (sTake ##0 (!cfgBinary && itemSelected && itemOrder <= cfgMaxOrder
      && !cfgThreeWire && cfgMotorVariant) |=> !itemReady [*8])
      else $error("kept ascii item finished too soon");
   AST_NO_EARLY: assert property (sTake ##0 !outValid |=> !outValid)
      else $error("byte appeared one edge after take");
   AST_CE_HOLD: assert property (!ce |-> !itemReady && !outValid && ($past(ce) || $stable(outData)))
      else $error("ports active or byte moved while frozen");
   AST_OUT_STAND: assert property (outValid && !outReady
      |=> !ce || (outValid && $stable(outData) && $stable(outEoi)))
      else $error("byte changed before it was taken");
   AST_EOI_TERM: assert property (outValid && outEoi && !cfgBinary |-> outData == `MDOF_CH_LF)
      else $error("ascii block end marker not on line feed");
endmodule

bind mdof_formatter mdof_formatter_asserts u_chk (.*);

// [verification/mdof_host_model.sv]
`timescale 1ns/100ps

// host side of the byte link: takes bytes fast, slowly, or not at all
module mdof_host_model (
   input  wire       clk_sys,   // system clock
   input  wire       rst,       // reset
   input  wire       outValid,  // byte offered
   input  wire [7:0] outData,   // byte
   input  wire       outEoi,    // end marker
   input  wire [1:0] mode,      // 0 fast, 1 every other cycle, else stopped
   output logic      outReady   // host takes byte
);
   logic [8:0] q[$];  // received marker and byte, in arrival order
   // ready low in reset, moves only at the falling edge
   always @(negedge clk_sys) outReady <= !rst && ((mode == 2'h0) || (mode == 2'h1 && !outReady));
   // keep every accepted byte with its marker
   always @(posedge clk_sys) if (!rst && outValid && outReady) q.push_back({outEoi, outData});
endmodule

// [verification/mdof_formatter_tb_top.sv]
`timescale 1ns/100ps
`include "mdof_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end

// self-checking bench for the harmonic output framer
module mdof_formatter_tb_top;
   logic        clk_sys, rst, ce, cfgBinary, cfgHeaderOn, cfgTermCrLf, cfgThreeWire, cfgMotorVariant;
   logic        itemValid, itemSelected, itemLineEnd, itemBlockEnd, itemNegative, itemPercent;
   logic        itemOverflow, itemIsTime, itemTimeValid;
   logic [1:0]  cfgLayout, itemScale, mode;
   logic [2:0]  itemPoint;
   logic [4:0]  itemLine;
   logic [5:0]  cfgMaxOrder, itemOrder;
   logic [7:0]  itemElement, itemState, itemPhase, itemMinutes, itemSeconds;
   logic [15:0] itemHours;
   logic [23:0] itemType, itemDigits;
   logic [31:0] itemFloat;
   wire         itemReady, outValid, outReady, outEoi;
   wire  [7:0]  outData;
   logic [7:0]  ex[$];  // expected bytes
   int          errCount, checked, cyc;

   mdof_formatter dut (.*);
   mdof_host_model host (.clk_sys(clk_sys), .rst(rst), .outValid(outValid), .outData(outData),
      .outEoi(outEoi), .mode(mode), .outReady(outReady));

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // offer one item and wait until it is taken
   task send(input logic le, input logic be); int n;
      itemLineEnd = le;
      itemBlockEnd = be;
      @(negedge clk_sys);
      itemValid = 1'b1;
      n = 0;
      while (itemReady !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      itemValid = 1'b0;
   endtask

   // append text to the expected bytes
   task put(input string s);
      for (int i = 0; i < s.len(); i++) ex.push_back(s[i]);
   endtask

   // compare received bytes, marker only on the last one
   task cmp; int n;
      n = 0;
      while (host.q.size() < ex.size() && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(host.q.size(), ex.size())
      foreach (ex[i]) if (i < host.q.size()) begin
         `CHK(host.q[i][7:0], ex[i])
         `CHK(host.q[i][8], i == ex.size() - 1)
      end
      host.q.delete();
      ex.delete();
   endtask

   // one ascii item per block, every exponent scale
   task tScale; string sx[4] = '{"-3", "+0", "+3", "+6"};
      {itemDigits, itemPoint} = {24'h123456, 3'h3};
      for (int k = 0; k < 4; k++) begin
         itemScale = k[1:0];
         send(1'b1, 1'b1);
         put({" 123.456E", sx[k], "\nEND\n"});
         cmp;
      end
   endtask

   // headers, percent field, commas, cr lf, full buffer with host stopped
   task tHeader;
      {cfgHeaderOn, cfgTermCrLf, cfgMaxOrder, mode} = {2'h3, 6'h08, 2'h2};
      {itemNegative, itemPercent, itemOrder, itemDigits, itemPoint} = {2'h3, 6'h05, 24'h012340, 3'h2};
      send(1'b0, 1'b0);
      itemOrder = 6'h09;  // above the maximum, so dropped
      send(1'b0, 1'b0);
      {itemNegative, itemPercent, itemOrder, itemDigits, itemPoint, itemScale} = {8'h00, 24'h999999, 3'h6, 2'h0};
      send(1'b1, 1'b1);
      repeat (60) @(negedge clk_sys);
      `CHK({itemReady, outValid}, 2'h1)
      mode = 2'h1;
      put("HVC1N05 -01.2340%  ,HVC1N    999999.E-3\r\nEND\r\n");
      cmp;
   endtask

   // dropped lines and items leave only the end line
   task tDrop; logic [15:0] tab[6] = '{16'hd093, 16'h3601, 16'h0f01, 16'h7501, 16'hb281, 16'hd080};
      {cfgHeaderOn, cfgTermCrLf, mode} = 4'h0;
      for (int k = 0; k < 6; k++) begin
         {cfgLayout, cfgThreeWire, cfgMotorVariant, itemLine, itemOrder, itemSelected} = tab[k];
         send(1'b0, 1'b0);
         itemSelected = 1'b0;
         send(1'b1, 1'b1);
         put("END\n");
         cmp;
      end
      {cfgLayout, cfgThreeWire, cfgMotorVariant, itemLine, itemOrder, itemSelected} = 16'hd081;
   endtask

   // binary words, special codes, elapsed time, freeze in mid-block
   task tBinary; logic [31:0] w[5] = '{32'h3fc00000, `MDOF_BIN_INF, `MDOF_BIN_INF, `MDOF_BIN_NAN, 32'h01020304};
      {cfgBinary, cfgHeaderOn, mode, itemOrder} = {2'h3, 2'h1, 6'h00};
      itemFloat = 32'h3fc00000;
      send(1'b1, 1'b0);
      ce = 1'b0;
      repeat (5) @(negedge clk_sys);
      `CHK({itemReady, outValid}, 2'h0)
      ce = 1'b1;
      itemOverflow = 1'b1;
      send(1'b1, 1'b0);
      {itemOverflow, itemFloat} = {1'b0, 32'h7f800000};
      send(1'b1, 1'b0);
      itemIsTime = 1'b1;
      send(1'b1, 1'b0);
      itemTimeValid = 1'b1;
      send(1'b1, 1'b1);
      foreach (w[i]) for (int b = 3; b >= 0; b--) ex.push_back(w[i][8*b +: 8]);
      cmp;
   endtask

   // print counts and verdict, then stop
   task printVerdict;
      $display("checked %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // cut a hung run short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errCount++;
         printVerdict;
      end
   end

   // main sequence
   initial begin
      rst = 1'b1;
      mode = 2'h0;
      {itemValid, itemNegative, itemPercent, itemOverflow, itemIsTime, itemTimeValid} = 6'h00;
      {cfgBinary, cfgHeaderOn, cfgTermCrLf, cfgThreeWire, itemLineEnd, itemBlockEnd} = 6'h00;
      {itemSelected, cfgMotorVariant, ce} = 3'h7;
      {cfgLayout, itemLine, cfgMaxOrder, itemOrder} = {2'h3, 5'h01, 6'h32, 6'h00};
      {itemType, itemElement, itemState, itemPhase} = "HVC1N ";
      {itemDigits, itemPoint, itemScale, itemFloat} = 61'h0;
      {itemHours, itemMinutes, itemSeconds} = 32'h01020304;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      tScale;
      tHeader;
      tDrop;
      tBinary;
      printVerdict;
   end
endmodule
